//--- design/sre_pkg.sv
// constants and types for the two-wire eeprom read sequencer
// Functional notes
// - counter holds last accessed address plus one
// - device acknowledges matching address on clock 9
// - shift out byte, then counter plus one; the counter steps in the same cycle that the byte is loaded and its first bit is driven
// - STOP after final byte returns to standby
// - controller ack on clock 18 gets next byte
// - bytes continue while every ninth-clock slot acknowledged
// - counter wraps from top address to zero
// - write-mode device address is acknowledged too
// - two address bytes acknowledged, counter loaded
// - new START abandons pending work, reads loaded address
// - array address is thirteen bits wide
// - device address 1010 plus chip select match
// - sample on rising, drive after falling clock
// - SDA fall/rise while SCL high: START/STOP
package sre_pkg;
    localparam int          ADDR_W     = 13;
    localparam int          BYTE_W     = 8;
    localparam int          CS_W       = 3;
    localparam int          SYNC_W     = 5;
    localparam int          ADDR_HI_W  = 5;
    localparam logic [3:0]  DEV_TYPE   = 4'hA;
    localparam logic [3:0]  BIT_ACK    = 4'h8;
    localparam logic [3:0]  BIT_END    = 4'h9;
    localparam logic [3:0]  BCNT_RST   = 4'h0;
    localparam logic [12:0] ADDR_RST   = 13'h0000;
    localparam logic [12:0] ADDR_FIRST = 13'h0000;
    localparam logic [12:0] ADDR_MAX   = 13'h1FFF;
    localparam logic [12:0] ADDR_STEP  = 13'h0001;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [7:0]  BYTE_IDLE  = 8'hFF;
    localparam logic        PIN_IDLE   = 1'b1;
    localparam logic        DRIVE_LVL  = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DEVADDR,
        ST_ADDR_HI,
        ST_ADDR_LO,
        ST_READ,
        ST_IGNORE
    } sre_state_t;
endpackage

//--- design/sre_sync.sv
// two-flop synchroniser for the pin inputs
`timescale 1ns/1ns
module sre_sync (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    // pins in, synchronised copies out
    input  wire logic [sre_pkg::SYNC_W-1:0] din,
    output logic      [sre_pkg::SYNC_W-1:0] dout
);
    import sre_pkg::*;

    logic [SYNC_W-1:0] meta;

    // first stage feeds only the second; idle-high reset matches pulled-up bus
    for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                meta[i] <= PIN_IDLE;
                dout[i] <= PIN_IDLE;
            end else begin
                meta[i] <= din[i];
                dout[i] <= meta[i];
            end
        end
    end
endmodule

//--- design/sre_buf.sv
// two-entry byte buffer between array reads and the shifter
`timescale 1ns/1ns
module sre_buf (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    input  wire logic                      flush,
    // fill side
    input  wire logic                      in_valid,
    output logic                           in_ready,
    input  wire logic [sre_pkg::BYTE_W-1:0] in_data,
    // drain side
    output logic                           out_valid,
    input  wire logic                      out_ready,
    output logic      [sre_pkg::BYTE_W-1:0] out_data
);
    import sre_pkg::*;

    logic [BYTE_W-1:0] mem [0:1];
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
    logic              push;
    logic              pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    // flush wins so a stale in-flight byte never lands
    assign push      = in_valid && in_ready && !flush;
    assign pop       = out_valid && out_ready && !flush;

    // storage carries no reset, only pointers and fill level do
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else if (flush) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

//--- design/sre_read_seq.sv
// read sequencer of a two-wire serial eeprom slave
`timescale 1ns/1ns
module sre_read_seq (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      resetn,
    // two-wire pins
    input  wire logic                      scl_pin,
    input  wire logic                      sda_in,
    output logic                           sda_out,
    output logic                           sda_oe,
    input  wire logic [sre_pkg::CS_W-1:0]   chip_select_pins,
    // array read port
    output logic                           mem_rd,
    output logic      [sre_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [sre_pkg::BYTE_W-1:0] mem_rdata,
    // status shared with the write logic
    output logic      [sre_pkg::ADDR_W-1:0] addr_count,
    output logic                           standby
);
    import sre_pkg::*;

    logic [SYNC_W-1:0] pins_s;
    logic              scl_s;
    logic              sda_s;
    logic [CS_W-1:0]   cs_s;
    logic              scl_q;
    logic              sda_q;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_ev;
    logic              stop_ev;
    logic              bus_ev;
    sre_state_t        state;
    logic [3:0]        bcnt;
    logic [BYTE_W-1:0] rx;
    logic [BYTE_W-1:0] tx;
    logic [BYTE_W-1:0] addr_hi;
    logic              ack_bit;
    logic              dev_match;
    logic              ack_fall;
    logic              end_fall;
    logic              load_byte;
    logic              addr_load;
    logic [ADDR_W-1:0] loaded_addr;
    logic              flush;
    logic [ADDR_W-1:0] flush_addr;
    logic [ADDR_W-1:0] fetch_ptr;
    logic              rd_wait;
    logic              issue;
    logic              buf_in_ready;
    logic              buf_valid;
    logic [BYTE_W-1:0] buf_data;
    logic [BYTE_W-1:0] next_tx;

    // pins and straps all cross into mclk before use
    sre_sync u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .din    ({chip_select_pins, sda_in, scl_pin}),
        .dout   (pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign cs_s  = pins_s[SYNC_W-1:2];

    // previous synchronised levels for edge finding
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_q <= PIN_IDLE;
            sda_q <= PIN_IDLE;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // line events; data moving while clock stays high is framing
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_ev = scl_s && scl_q && sda_q && !sda_s;
    assign stop_ev  = scl_s && scl_q && !sda_q && sda_s;
    assign bus_ev   = scl_fall || start_ev || stop_ev;

    // byte-level decode
    assign dev_match   = (rx[7:4] == DEV_TYPE) && (rx[3:1] == cs_s);
    assign ack_fall    = scl_fall && (bcnt == BIT_ACK);
    assign end_fall    = scl_fall && (bcnt == BIT_END);
    assign load_byte   = end_fall && (((state == ST_DEVADDR) && rx[0]) ||
                                      ((state == ST_READ) && !ack_bit));
    assign addr_load   = end_fall && (state == ST_ADDR_LO);
    // top three bits of the high address byte are dropped
    assign loaded_addr = {addr_hi[ADDR_HI_W-1:0], rx};
    assign flush       = start_ev || addr_load;
    assign flush_addr  = addr_load ? loaded_addr : addr_count;
    // fetch only with no read outstanding and room for the answer
    assign issue       = !mem_rd && !rd_wait && buf_in_ready && !flush;
    assign next_tx     = buf_valid ? buf_data : BYTE_IDLE;

    // sequencing and bit count
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            bcnt  <= BCNT_RST;
        end else if (stop_ev) begin
            state <= ST_IDLE;
            bcnt  <= BCNT_RST;
        end else if (start_ev) begin
            state <= ST_DEVADDR;
            bcnt  <= BCNT_RST;
        end else if (state != ST_IDLE) begin
            if (scl_rise && (bcnt < BIT_END)) begin
                bcnt <= bcnt + 4'h1;
            end else if (end_fall) begin
                bcnt <= BCNT_RST;
            end
            if (ack_fall && (state == ST_DEVADDR) && !dev_match) begin
                state <= ST_IDLE;
            end else if (end_fall) begin
                case (state)
                    ST_DEVADDR: state <= rx[0] ? ST_READ : ST_ADDR_HI;
                    ST_ADDR_HI: state <= ST_ADDR_LO;
                    ST_ADDR_LO: state <= ST_IGNORE; // data bytes belong to the write path
                    ST_READ:    state <= ack_bit ? ST_IGNORE : ST_READ;
                    default:    state <= state;
                endcase
            end
        end
    end

    // incoming bits on rising clock, most significant first
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rx <= BYTE_RST;
        end else if (scl_rise && (bcnt < BIT_ACK)) begin
            rx <= {rx[BYTE_W-2:0], sda_s};
        end
    end

    // controller answer in the ninth slot of a read byte
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ack_bit <= PIN_IDLE;
        end else if (scl_rise && (bcnt == BIT_ACK)) begin
            ack_bit <= sda_s;
        end
    end

    // high address byte held until the low byte completes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            addr_hi <= BYTE_RST;
        end else if (end_fall && (state == ST_ADDR_HI)) begin
            addr_hi <= rx;
        end
    end

    // shared counter: load from address phase, step per byte sent
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            addr_count <= ADDR_RST;
        end else if (addr_load) begin
            addr_count <= loaded_addr;
        end else if (load_byte) begin
            addr_count <= addr_count + ADDR_STEP;
        end
    end

    // data line driver: changes only after a falling clock or framing
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_oe <= 1'b0;
            tx     <= BYTE_RST;
        end else if (start_ev || stop_ev) begin
            sda_oe <= 1'b0;
        end else if (load_byte) begin
            tx     <= next_tx;
            sda_oe <= !next_tx[BYTE_W-1];
        end else if (end_fall) begin
            sda_oe <= 1'b0;
        end else if (ack_fall) begin
            case (state)
                ST_DEVADDR: sda_oe <= dev_match;
                ST_ADDR_HI: sda_oe <= 1'b1;
                ST_ADDR_LO: sda_oe <= 1'b1;
                default:    sda_oe <= 1'b0; // release for the controller's answer
            endcase
        end else if (scl_fall && (state == ST_READ) && (bcnt != BCNT_RST)) begin
            tx     <= {tx[BYTE_W-2:0], 1'b0};
            sda_oe <= !tx[BYTE_W-2];
        end
    end

    // open-drain: only ever pulls low
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_out <= DRIVE_LVL;
        end else begin
            sda_out <= DRIVE_LVL;
        end
    end

    // standby mirrors the idle state one cycle late
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            standby <= 1'b1;
        end else begin
            standby <= (state == ST_IDLE);
        end
    end

    // prefetch runs ahead of the counter so a byte waits at each slot
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mem_rd    <= 1'b0;
            rd_wait   <= 1'b0;
            mem_addr  <= ADDR_RST;
            fetch_ptr <= ADDR_RST;
        end else begin
            mem_rd  <= issue;
            rd_wait <= mem_rd && !flush;
            if (issue) begin
                mem_addr <= fetch_ptr;
            end
            if (flush) begin
                fetch_ptr <= flush_addr;
            end else if (issue) begin
                fetch_ptr <= fetch_ptr + ADDR_STEP;
            end
        end
    end

    // answers land here; a stalled shifter stops further fetches
    sre_buf u_buf (
        .mclk      (mclk),
        .resetn    (resetn),
        .flush     (flush),
        .in_valid  (rd_wait),
        .in_ready  (buf_in_ready),
        .in_data   (mem_rdata),
        .out_valid (buf_valid),
        .out_ready (load_byte),
        .out_data  (buf_data)
    );

    // checks on the protocol behaviour
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    sequence s_read_ack;
        end_fall && (state == ST_READ) && !ack_bit;
    endsequence

    sequence s_next_byte;
        (state == ST_READ) && (bcnt == BCNT_RST) && (tx == $past(next_tx));
    endsequence

    property p_more_data;
        s_read_ack |=> s_next_byte ##0 (sda_oe == !tx[BYTE_W-1]);
    endproperty

    ack_dev_match_a: assert property (
        ack_fall && (state == ST_DEVADDR) && dev_match |=> sda_oe [*4]
    ) else $error("matching device address not acknowledged");

    nack_foreign_a: assert property (
        ack_fall && (state == ST_DEVADDR) && !dev_match |=> !sda_oe && (state == ST_IDLE)
    ) else $error("foreign device address was answered");

    ack_addr_a: assert property (
        ack_fall && ((state == ST_ADDR_HI) || (state == ST_ADDR_LO)) |=> sda_oe
    ) else $error("address byte not acknowledged");

    addr_load_a: assert property (
        addr_load |=> (addr_count == $past(loaded_addr)) ##1 (mem_rd && (mem_addr == addr_count))
    ) else $error("loaded address not fetched");

    count_step_a: assert property (
        load_byte |=> addr_count == $past(addr_count) + ADDR_STEP
    ) else $error("counter did not step after a byte");

    count_wrap_a: assert property (
        load_byte && (addr_count == ADDR_MAX) |=> addr_count == ADDR_FIRST
    ) else $error("counter did not wrap to the first address");

    more_data_a: assert property (p_more_data)
        else $error("acknowledged byte not followed by the next");

    start_restart_a: assert property (
        start_ev |=> (state == ST_DEVADDR) && (bcnt == BCNT_RST) && !sda_oe
    ) else $error("start did not restart the command");

    stop_standby_a: assert property (
        stop_ev |-> ##2 standby
    ) else $error("stop did not reach standby");

    edge_drive_a: assert property (
        $changed(sda_oe) |-> $past(bus_ev)
    ) else $error("data line moved outside a falling clock");

    nack_end_a: assert property (
        end_fall && (state == ST_READ) && ack_bit |=> (state == ST_IGNORE) && !sda_oe
    ) else $error("unacknowledged byte was followed by more data");

    start_wake_a: assert property (
        start_ev |-> ##2 !standby
    ) else $error("start did not leave standby");
endmodule

//--- verif/sre_bus_ctl.sv
// bus controller model driving the two-wire pins from the far side
`timescale 1ns/1ns
module sre_bus_ctl (
    // clock used to pace the model
    input  wire logic mclk,
    // two-wire pins as the controller sees them
    output logic      scl_pin,
    output logic      ctl_sda,
    input  wire logic sda_wire
);
    // bus idles with both lines released high
    initial begin
        scl_pin = 1'b1;
        ctl_sda = 1'b1;
    end

    // wait a number of system clocks
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one bit slot; data moves 2 clocks after scl falls so it never looks like START or STOP
    task automatic bit_slot(input logic b, output logic r);
        hold(2);
        ctl_sda <= b;
        hold(6);
        scl_pin <= 1'b1;
        hold(4);
        @(negedge mclk);
        r = sda_wire;
        hold(4);
        scl_pin <= 1'b0;
    endtask

    // start or repeated start; waits for the device to drop a pending ack first
    task automatic start_cond();
        ctl_sda <= 1'b1;
        hold(6);
        scl_pin <= 1'b1;
        hold(8);
        ctl_sda <= 1'b0;
        hold(8);
        scl_pin <= 1'b0;
    endtask

    // stop from a low clock
    task automatic stop_cond();
        hold(2);
        ctl_sda <= 1'b0;
        hold(6);
        scl_pin <= 1'b1;
        hold(8);
        ctl_sda <= 1'b1;
        hold(8);
    endtask

    // send a byte, most significant bit first, then read the ack slot
    task automatic send_byte(input logic [7:0] v, output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(v[i], r);
        end
        bit_slot(1'b1, r);
        acked = (r === 1'b0);
    endtask

    // receive a byte, then ack to ask for more or leave the slot high to end
    task automatic recv_byte(input logic give_ack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, r);
            v[i] = r;
        end
        bit_slot(!give_ack, r);
    endtask
endmodule

//--- verif/serial_eeprom_read_sequencer_tb_top.sv
// self-checking bench for the two-wire eeprom read sequencer
`timescale 1ns/1ns
module serial_eeprom_read_sequencer_tb_top;
    import sre_pkg::*;
    logic              mclk;
    logic              resetn           = 1'b0;
    logic              scl_pin;
    logic              ctl_sda;
    logic              sda_wire;
    logic              sda_out;
    logic              sda_oe;
    logic [CS_W-1:0]   chip_select_pins = 3'h0;
    logic              mem_rd;
    logic [ADDR_W-1:0] mem_addr;
    logic [BYTE_W-1:0] mem_rdata        = 8'h00;
    logic [ADDR_W-1:0] addr_count;
    logic              standby;
    int                miscompares      = 0;
    int                samples_checked  = 0;
    int                cycles           = 0;

    // open-drain wire: either party pulls low, pull-up otherwise
    assign sda_wire = (sda_oe && sda_out == DRIVE_LVL) ? 1'b0 : ctl_sda;

    sre_read_seq i_dut (.mclk(mclk), .resetn(resetn), .scl_pin(scl_pin), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_pins(chip_select_pins), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .addr_count(addr_count), .standby(standby));

    sre_bus_ctl i_ctl (.mclk(mclk), .scl_pin(scl_pin), .ctl_sda(ctl_sda), .sda_wire(sda_wire));

    // array content, distinct for neighbouring addresses
    function automatic logic [BYTE_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ {a[12:8], 3'h5};
    endfunction

    // array model; data lasts one cycle so a late capture shows up
    always @(posedge mclk) begin
        if (mem_rd)
            mem_rdata <= pat(mem_addr);
        else
            mem_rdata <= ~mem_rdata;
    end

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic summarize();
        $display("checks made %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // hang guard, well above the few thousand clocks the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            $display("ERROR %0t timeout", $time);
            summarize();
        end
    end

    task automatic chk_bit(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [BYTE_W-1:0] got, input logic [BYTE_W-1:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_addr(input logic [ADDR_W-1:0] got, input logic [ADDR_W-1:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    // reset values, also after traffic has moved the counter
    task automatic t_reset();
        resetn <= 1'b0;
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        chk_bit(standby, 1'b1, "standby in reset");
        chk_bit(sda_oe, 1'b0, "pin released in reset");
        chk_bit(sda_out, DRIVE_LVL, "data value only pulls low");
        chk_addr(addr_count, ADDR_RST, "counter in reset");
        @(posedge mclk);
        resetn <= 1'b1;
        i_ctl.hold(8);
    endtask

    // strap pins are synchronised, so give them a few clocks
    task automatic set_cs(input logic [CS_W-1:0] v);
        chip_select_pins <= v;
        i_ctl.hold(4);
    endtask

    // dummy-write address phase; top three bits of the high byte are set and must be ignored
    task automatic load_addr(input logic [ADDR_W-1:0] a);
        logic ack;
        i_ctl.start_cond();
        i_ctl.send_byte({DEV_TYPE, chip_select_pins, 1'b0}, ack);
        chk_bit(ack, 1'b1, "write device byte ack");
        i_ctl.send_byte({3'h7, a[12:8]}, ack);
        chk_bit(ack, 1'b1, "high address ack");
        i_ctl.send_byte(a[7:0], ack);
        chk_bit(ack, 1'b1, "low address ack");
        // the counter loads only once the synchronised ninth clock fall is seen
        i_ctl.hold(4);
        chk_addr(addr_count, a, "loaded counter");
    endtask

    // read n bytes from the counter, stalling with scl low before each byte
    task automatic read_run(input logic [ADDR_W-1:0] first, input int n, input int stall);
        logic              ack;
        logic [BYTE_W-1:0] got;
        logic [ADDR_W-1:0] exp;
        exp = first;
        i_ctl.start_cond();
        i_ctl.send_byte({DEV_TYPE, chip_select_pins, 1'b1}, ack);
        chk_bit(ack, 1'b1, "read device byte ack");
        chk_bit(standby, 1'b0, "awake during read");
        for (int i = 0; i < n; i++) begin
            i_ctl.hold(stall);
            i_ctl.recv_byte(i < n - 1, got);
            chk_byte(got, pat(exp), "read data");
            exp = exp + ADDR_STEP;
        end
        i_ctl.stop_cond();
        i_ctl.hold(8);
        chk_addr(addr_count, exp, "counter after read");
        chk_bit(standby, 1'b1, "standby after stop");
    endtask

    // random read of one byte
    task automatic t_random_read();
        set_cs(3'h5);
        load_addr(13'h0123);
        read_run(13'h0123, 1, 0);
    endtask

    // current-address read continues from the counter
    task automatic t_current_read();
        read_run(13'h0124, 2, 0);
    endtask

    // sequential read across the top of the array
    task automatic t_seq_wrap();
        load_addr(ADDR_MAX - 13'h0001);
        read_run(ADDR_MAX - 13'h0001, 4, 0);
    endtask

    // long scl-low stalls while the buffer sits full
    task automatic t_stall();
        set_cs(3'h2);
        load_addr(13'h0A5A);
        read_run(13'h0A5A, 3, 150);
    endtask

    // wrong type nibble or wrong chip select gets no ack and leaves the counter alone
    task automatic t_bad_addr();
        logic [7:0]        bad [2];
        logic              ack;
        logic [ADDR_W-1:0] keep;
        bad[0] = {4'hB, chip_select_pins, 1'b1};
        bad[1] = {DEV_TYPE, chip_select_pins ^ 3'h1, 1'b1};
        keep = addr_count;
        for (int i = 0; i < 2; i++) begin
            i_ctl.start_cond();
            i_ctl.send_byte(bad[i], ack);
            chk_bit(ack, 1'b0, "foreign device byte ack");
            i_ctl.stop_cond();
            i_ctl.hold(8);
            chk_bit(standby, 1'b1, "standby after foreign byte");
            chk_addr(addr_count, keep, "counter kept");
        end
    endtask

    initial begin
        t_reset();
        t_random_read();
        t_current_read();
        t_seq_wrap();
        t_bad_addr();
        t_stall();
        t_reset();
        // after a mid-run reset the counter starts again from its reset value
        read_run(ADDR_RST, 1, 0);
        summarize();
    end
endmodule
